// ===== hdl/pfm_pkg.sv
// Constants shared by the port 2/3/4 pin function multiplexer.
// Assumes a Wishbone slave with 32-bit data and word-aligned registers.
package pfm_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_P2_DATA = 6'h06;
  localparam logic [5:0] IDX_P2_DIR = 6'h08;
  localparam logic [5:0] IDX_P2_FUNC = 6'h09;
  localparam logic [5:0] IDX_P3_DATA = 6'h0C;
  localparam logic [5:0] IDX_P3_FUNC2 = 6'h0D;
  localparam logic [5:0] IDX_P3_DIR = 6'h0E;
  localparam logic [5:0] IDX_P3_FUNC = 6'h0F;
  localparam logic [5:0] IDX_P4_DATA = 6'h10;
  localparam logic [5:0] IDX_P4_FUNC2 = 6'h11;
  localparam logic [5:0] IDX_P4_DIR = 6'h12;
  localparam logic [5:0] IDX_P4_FUNC = 6'h13;
  localparam logic [5:0] IDX_ODE = 6'h20;
  // Reset values.
  localparam logic [7:0] P2_LAT_RST = 8'hFF;
  localparam logic [3:0] P3_LAT_RST = 4'hF;
  localparam logic [4:0] P4_LAT_RST = 5'h1F;
  localparam logic [7:0] P2_CTL_RST = 8'h00;
  localparam logic [3:0] P3_CTL_RST = 4'h0;
  localparam logic [4:0] P4_CTL_RST = 5'h00;
  // Implemented second-function bits of port 4 (pins 0, 1 and 3).
  localparam logic [4:0] P4_FUNC2_MASK = 5'h0B;
  // Open-drain enable bit positions.
  localparam int ODE_P30 = 0;
  localparam int ODE_P31 = 1;
  localparam int ODE_P41 = 2;
  // Selection codes {second function, function, direction}.
  localparam logic [2:0] CODE_IN = 3'h0;
  localparam logic [2:0] CODE_OUT = 3'h1;
  localparam logic [2:0] CODE_F_IN = 3'h2;
  localparam logic [2:0] CODE_F_OUT = 3'h3;
  localparam logic [2:0] CODE_F2_IN = 3'h4;
  localparam logic [2:0] CODE_F2_OUT = 3'h5;
  localparam logic [2:0] CODE_F12_OUT = 3'h7;
endpackage : pfm_pkg

// ===== hdl/pfm_port_mux.sv
// Pin function multiplexer for port 2 (8 bits), port 3 and port 4.
// Assumes pin inputs are synchronous to clk_i and a Wishbone master.
// Summary of operation
// R1: Port2 reset: latch ones, control zero, inputs.
// R2: Port2 plain mode: direction picks input or latch.
// R3: Port2 function: address low or high byte.
// R4: Software writes direction before function for high.
// R5: Software avoids read-modify-write on control registers.
// R6: Data register reads return pin levels.
// R7: Port3 reset: latch ones, controls zero, inputs.
// R8: Port3 alternates only via function bits.
// R9: Port3 input functions: wait, capture, interrupts.
// R10: Port3 outputs timer outputs on pins 3, 2.
// R11: Port3 pins 1, 0 carry serial bus.
// R12: Port3 pins 0, 1 open-drain per enable.
// R13: Software clears pin2 direction, sets wait mode.
// R14: Port4 reset: inputs, pull-ups on, latch ones.
// R15: Port4 reset clears all control registers.
// R16: Port4 offers chip selects, serial, ALE, clock.
// R17: Port4 pin 1 open-drain per enable.
// R18: Port4 input latch bit controls pull-up.
// R19: Software sets function before direction for selects.
// R20: Reserved codes disable driver and routing; the receive line still sees port4 pin 2.
// R21: Port3 upper bits read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module pfm_port_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] port2_in_i,
  output logic [7:0] port2_out_o,
  output logic [7:0] port2_oe_o,
  input wire logic [3:0] port3_in_i,
  output logic [3:0] port3_out_o,
  output logic [3:0] port3_oe_o,
  input wire logic [4:0] port4_in_i,
  output logic [4:0] port4_out_o,
  output logic [4:0] port4_oe_o,
  output logic [4:0] port4_pullup_o,
  input wire logic [23:0] address_i,
  input wire logic timer_output_zero_i,
  input wire logic timer_output_one_i,
  input wire logic serial_bus_clock_drive_i,
  input wire logic serial_bus_data_drive_i,
  input wire logic [3:0] chip_select_i,
  input wire logic address_latch_enable_i,
  input wire logic serial_channel_transmit_i,
  input wire logic serial_channel_clock_drive_i,
  input wire logic system_clock_output_i,
  output logic bus_wait_o,
  output logic external_interrupt_three_o,
  output logic external_interrupt_four_o,
  output logic timer_capture_input_zero_o,
  output logic timer_capture_input_one_o,
  output logic serial_bus_clock_line_o,
  output logic serial_bus_data_line_o,
  output logic serial_channel_receive_o,
  output logic serial_channel_clock_or_cts_o
);

  typedef struct packed {
    logic [7:0] p2_lat;
    logic [7:0] p2_dir;
    logic [7:0] p2_fc;
    logic [3:0] p3_lat;
    logic [3:0] p3_dir;
    logic [3:0] p3_fc;
    logic [1:0] p3_fc2;
    logic [4:0] p4_lat;
    logic [4:0] p4_dir;
    logic [4:0] p4_fc;
    logic [4:0] p4_fc2;
    logic [2:0] ode;
    logic ack;
    logic [31:0] dat;
    logic [7:0] p2_out;
    logic [7:0] p2_oe;
    logic [3:0] p3_out;
    logic [3:0] p3_oe;
    logic [4:0] p4_out;
    logic [4:0] p4_oe;
    logic [4:0] p4_pu;
    logic bus_wait;
    logic external_interrupt_three;
    logic external_interrupt_four;
    logic cap0;
    logic cap1;
    logic scl_in;
    logic sda_in;
    logic rxd;
    logic sclk_cts;
  } pfm_state_s;

  pfm_state_s st_reg;
  pfm_state_s st_next;

  function automatic logic [2:0] pfm_code(input logic f2, input logic f, input logic c);
    pfm_code = {f2, f, c};
  endfunction : pfm_code

  // An open-drain pin only ever pulls low; a high value releases it.
  function automatic logic pfm_drive(input logic en, input logic od, input logic val);
    pfm_drive = en & ~(od & val);
  endfunction : pfm_drive

  always_comb begin
    logic req;
    logic wr;
    logic [5:0] idx;
    logic [2:0] code;
    logic [2:0] code0;
    logic [2:0] code1;
    logic [2:0] code2;
    logic [2:0] code3;
    req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    idx = wb_adr_i[7:2];
    code = 3'h0;
    st_next = st_reg;
    st_next.ack = req;
    if (req && !wb_we_i) begin
      st_next.dat = 32'h0000_0000;
      case (idx)
        pfm_pkg::IDX_P2_DATA: st_next.dat[7:0] = port2_in_i; // R6
        pfm_pkg::IDX_P3_DATA: st_next.dat[3:0] = port3_in_i; // R6 R21
        pfm_pkg::IDX_P4_DATA: st_next.dat[4:0] = port4_in_i; // R6
        pfm_pkg::IDX_ODE: st_next.dat[2:0] = st_reg.ode;
        default: st_next.dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (idx)
        pfm_pkg::IDX_P2_DATA: st_next.p2_lat = wb_dat_i[7:0];
        pfm_pkg::IDX_P2_DIR: st_next.p2_dir = wb_dat_i[7:0];
        pfm_pkg::IDX_P2_FUNC: st_next.p2_fc = wb_dat_i[7:0];
        pfm_pkg::IDX_P3_DATA: st_next.p3_lat = wb_dat_i[3:0]; // R21
        pfm_pkg::IDX_P3_DIR: st_next.p3_dir = wb_dat_i[3:0]; // R21
        pfm_pkg::IDX_P3_FUNC: st_next.p3_fc = wb_dat_i[3:0]; // R8 R21
        pfm_pkg::IDX_P3_FUNC2: st_next.p3_fc2 = wb_dat_i[1:0]; // R21
        pfm_pkg::IDX_P4_DATA: st_next.p4_lat = wb_dat_i[4:0];
        pfm_pkg::IDX_P4_DIR: st_next.p4_dir = wb_dat_i[4:0];
        pfm_pkg::IDX_P4_FUNC: st_next.p4_fc = wb_dat_i[4:0];
        pfm_pkg::IDX_P4_FUNC2: st_next.p4_fc2 = wb_dat_i[4:0] & pfm_pkg::P4_FUNC2_MASK;
        pfm_pkg::IDX_ODE: st_next.ode = wb_dat_i[2:0];
        default: st_next.ack = req;
      endcase
    end
    // Pin drivers follow the current settings; they lag a write by one cycle.
    for (int n = 0; n < 8; n++) begin
      if (st_reg.p2_fc[n]) begin
        st_next.p2_oe[n] = 1'b1; // R3
        st_next.p2_out[n] = st_reg.p2_dir[n] ? address_i[16 + n] : address_i[n]; // R3
      end else begin
        st_next.p2_oe[n] = st_reg.p2_dir[n]; // R2
        st_next.p2_out[n] = st_reg.p2_lat[n]; // R2
      end
    end
    for (int n = 0; n < 4; n++) begin
      code = pfm_code((n < 2) ? st_reg.p3_fc2[n % 2] : 1'b0, st_reg.p3_fc[n], st_reg.p3_dir[n]);
      st_next.p3_out[n] = st_reg.p3_lat[n];
      st_next.p3_oe[n] = 1'b0; // R20
      case (code)
        pfm_pkg::CODE_OUT: st_next.p3_oe[n] = 1'b1;
        pfm_pkg::CODE_F_OUT: begin
          if (n == 3) begin
            st_next.p3_out[n] = timer_output_one_i; // R10
            st_next.p3_oe[n] = 1'b1;
          end else if (n == 2) begin
            st_next.p3_out[n] = timer_output_zero_i; // R10
            st_next.p3_oe[n] = 1'b1;
          end
        end
        pfm_pkg::CODE_F2_OUT: begin
          if (n == 1) begin
            st_next.p3_out[n] = serial_bus_clock_drive_i; // R11
            st_next.p3_oe[n] = 1'b1;
          end else if (n == 0) begin
            st_next.p3_out[n] = serial_bus_data_drive_i; // R11
            st_next.p3_oe[n] = 1'b1;
          end
        end
        default: st_next.p3_oe[n] = 1'b0; // R20
      endcase
    end
    st_next.p3_oe[0] = pfm_drive(st_next.p3_oe[0], st_reg.ode[pfm_pkg::ODE_P30],
                                 st_next.p3_out[0]); // R12
    st_next.p3_oe[1] = pfm_drive(st_next.p3_oe[1], st_reg.ode[pfm_pkg::ODE_P31],
                                 st_next.p3_out[1]); // R12
    code0 = pfm_code(st_reg.p3_fc2[0], st_reg.p3_fc[0], st_reg.p3_dir[0]);
    code1 = pfm_code(st_reg.p3_fc2[1], st_reg.p3_fc[1], st_reg.p3_dir[1]);
    code2 = pfm_code(1'b0, st_reg.p3_fc[2], st_reg.p3_dir[2]);
    // Deselected inputs rest at their idle level so peripherals see no event.
    st_next.bus_wait = (code2 == pfm_pkg::CODE_F_IN) ? port3_in_i[2] : 1'b1; // R9
    st_next.cap1 = (code1 == pfm_pkg::CODE_F_IN) & port3_in_i[1]; // R9
    st_next.external_interrupt_four = (code1 == pfm_pkg::CODE_F_IN) & port3_in_i[1]; // R9
    st_next.cap0 = (code0 == pfm_pkg::CODE_F_IN) & port3_in_i[0]; // R9
    st_next.external_interrupt_three = (code0 == pfm_pkg::CODE_F_IN) & port3_in_i[0]; // R9
    st_next.scl_in = (code1 == pfm_pkg::CODE_F2_OUT) ? port3_in_i[1] : 1'b1; // R11
    st_next.sda_in = (code0 == pfm_pkg::CODE_F2_OUT) ? port3_in_i[0] : 1'b1; // R11
    for (int n = 0; n < 5; n++) begin
      code = pfm_code(st_reg.p4_fc2[n], st_reg.p4_fc[n], st_reg.p4_dir[n]);
      st_next.p4_out[n] = st_reg.p4_lat[n];
      st_next.p4_oe[n] = 1'b0; // R20
      case (code)
        pfm_pkg::CODE_OUT: st_next.p4_oe[n] = 1'b1;
        pfm_pkg::CODE_F_OUT: begin
          st_next.p4_oe[n] = 1'b1; // R16
          st_next.p4_out[n] = (n == 4) ? address_latch_enable_i : chip_select_i[n % 4];
        end
        pfm_pkg::CODE_F2_OUT: begin
          st_next.p4_oe[n] = 1'b1; // R16
          if (n == 0) begin
            st_next.p4_out[n] = system_clock_output_i;
          end else if (n == 1) begin
            st_next.p4_out[n] = serial_channel_transmit_i;
          end else if (n == 3) begin
            st_next.p4_out[n] = serial_channel_clock_drive_i;
          end
        end
        pfm_pkg::CODE_F12_OUT: begin
          if (n == 4) begin
            st_next.p4_oe[n] = 1'b1; // R16
            st_next.p4_out[n] = address_latch_enable_i;
          end else if (n == 2) begin
            st_next.p4_oe[n] = 1'b1; // R16
            st_next.p4_out[n] = chip_select_i[2];
          end
        end
        default: st_next.p4_oe[n] = 1'b0; // R20
      endcase
      st_next.p4_pu[n] = ~st_reg.p4_dir[n] & st_reg.p4_lat[n]; // R18
    end
    st_next.p4_oe[1] = pfm_drive(st_next.p4_oe[1], st_reg.ode[pfm_pkg::ODE_P41],
                                 st_next.p4_out[1]); // R17
    code3 = pfm_code(st_reg.p4_fc2[3], st_reg.p4_fc[3], st_reg.p4_dir[3]);
    // The receive line has no selector of its own: it always sees pin 2.
    st_next.rxd = port4_in_i[2]; // R16
    st_next.sclk_cts = (code3 == pfm_pkg::CODE_IN) ? port4_in_i[3] : 1'b1; // R16
    if (rst_i) begin
      st_next = '0;
      st_next.p2_lat = pfm_pkg::P2_LAT_RST; // R1
      st_next.p2_dir = pfm_pkg::P2_CTL_RST; // R1
      st_next.p2_fc = pfm_pkg::P2_CTL_RST; // R1
      st_next.p3_lat = pfm_pkg::P3_LAT_RST; // R7
      st_next.p3_dir = pfm_pkg::P3_CTL_RST; // R7
      st_next.p4_lat = pfm_pkg::P4_LAT_RST; // R14
      st_next.p4_dir = pfm_pkg::P4_CTL_RST; // R15
      st_next.p4_fc = pfm_pkg::P4_CTL_RST; // R15
      st_next.p4_pu = pfm_pkg::P4_LAT_RST; // R14
      st_next.bus_wait = 1'b1;
      st_next.scl_in = 1'b1;
      st_next.sda_in = 1'b1;
      st_next.rxd = 1'b1;
      st_next.sclk_cts = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign port2_out_o = st_reg.p2_out;
  assign port2_oe_o = st_reg.p2_oe;
  assign port3_out_o = st_reg.p3_out;
  assign port3_oe_o = st_reg.p3_oe;
  assign port4_out_o = st_reg.p4_out;
  assign port4_oe_o = st_reg.p4_oe;
  assign port4_pullup_o = st_reg.p4_pu;
  assign bus_wait_o = st_reg.bus_wait;
  assign external_interrupt_three_o = st_reg.external_interrupt_three;
  assign external_interrupt_four_o = st_reg.external_interrupt_four;
  assign timer_capture_input_zero_o = st_reg.cap0;
  assign timer_capture_input_one_o = st_reg.cap1;
  assign serial_bus_clock_line_o = st_reg.scl_in;
  assign serial_bus_data_line_o = st_reg.sda_in;
  assign serial_channel_receive_o = st_reg.rxd;
  assign serial_channel_clock_or_cts_o = st_reg.sclk_cts;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_p2_reset: assert property ($past(rst_i) |-> st_reg.p2_lat == 8'hFF
    && st_reg.p2_dir == 8'h00 && st_reg.p2_fc == 8'h00 && port2_oe_o == 8'h00) // R1
    else $error("port2 reset state wrong");
  a_p3_reset: assert property ($past(rst_i) |-> st_reg.p3_lat == 4'hF
    && st_reg.p3_fc == 4'h0 && st_reg.p3_fc2 == 2'h0 && port3_oe_o == 4'h0) // R7
    else $error("port3 reset state wrong");
  a_p4_reset: assert property ($past(rst_i) |-> port4_pullup_o == 5'h1F
    && st_reg.p4_fc == 5'h00 && st_reg.p4_fc2 == 5'h00 && port4_oe_o == 5'h00) // R14 R15
    else $error("port4 reset state wrong");
  a_p2_plain_io: assert property (st_reg.p2_fc == 8'h00 && !$past(rst_i) |=>
    port2_oe_o == $past(st_reg.p2_dir) && port2_out_o == $past(st_reg.p2_lat)) // R2
    else $error("port2 plain io wrong");
  a_p2_address: assert property (st_reg.p2_fc == 8'hFF && st_reg.p2_dir == 8'hFF |=>
    port2_oe_o == 8'hFF && port2_out_o == $past(address_i[23:16])) // R3
    else $error("port2 high address wrong");
  a_pin_readback: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i[7:2] == pfm_pkg::IDX_P2_DATA |=> wb_ack_o
    && wb_dat_o == {24'h000000, $past(port2_in_i)}) // R6
    else $error("port2 read not pin level");
  a_p3_upper_zero: assert property (wb_ack_o && wb_adr_i[7:2] == pfm_pkg::IDX_P3_DATA
    |-> wb_dat_o[31:4] == 28'h0000000) // R21
    else $error("port3 upper bits not zero");
  a_p3_wait_route: assert property (!st_reg.p3_fc2[0] && st_reg.p3_fc[2] && !st_reg.p3_dir[2]
    |=> bus_wait_o == $past(port3_in_i[2])) // R9
    else $error("wait input not routed");
  a_p3_timer_out: assert property (st_reg.p3_fc[3] && st_reg.p3_dir[3] |=>
    port3_oe_o[3] && port3_out_o[3] == $past(timer_output_one_i)) // R10
    else $error("timer output one not driven");
  a_p3_reserved: assert property (st_reg.p3_fc[1] && st_reg.p3_dir[1] |=>
    !port3_oe_o[1] && !timer_capture_input_one_o) // R20
    else $error("reserved code drives pin");
  a_p3_open_drain: assert property (st_reg.ode[0] && st_reg.p3_fc2[0] && !st_reg.p3_fc[0]
    && st_reg.p3_dir[0] && serial_bus_data_drive_i |=> !port3_oe_o[0]) // R12 R11
    else $error("open drain drove high");
  a_p4_pullup: assert property (!st_reg.p4_dir[0] && !$past(rst_i) |=>
    port4_pullup_o[0] == $past(st_reg.p4_lat[0])) // R18
    else $error("port4 pullup wrong");
  a_p4_select: assert property (st_reg.p4_fc[0] && st_reg.p4_dir[0] && !st_reg.p4_fc2[0]
    && !st_reg.ode[pfm_pkg::ODE_P41] |=> port4_oe_o[0]
    && port4_out_o[0] == $past(chip_select_i[0])) // R16
    else $error("chip select zero not driven");
  c_p2_high_addr: cover property (st_reg.p2_fc == 8'hFF && st_reg.p2_dir == 8'hFF);
  c_p3_serial: cover property (st_reg.p3_fc2 == 2'h3 && st_reg.p3_dir[1:0] == 2'h3);
  c_p4_txd_od: cover property (st_reg.ode[pfm_pkg::ODE_P41] && st_reg.p4_fc2[1]);
  c_bus_write: cover property (wb_ack_o && wb_we_i);

endmodule : pfm_port_mux
`default_nettype wire

// ===== sim/pfm_ext_model.sv
// Model of the memory and peripherals wired to port 2, 3 and 4 pins.
// Assumes the bench sets the level that outside parties put on undriven pins.
`timescale 1ns/10ps
`default_nettype none
module pfm_ext_model (
  input wire logic [7:0] p2_out_i,
  input wire logic [7:0] p2_oe_i,
  input wire logic [7:0] p2_ext_i,
  output logic [7:0] p2_pin_o,
  input wire logic [3:0] p3_out_i,
  input wire logic [3:0] p3_oe_i,
  input wire logic [3:0] p3_ext_i,
  output logic [3:0] p3_pin_o,
  input wire logic [4:0] p4_out_i,
  input wire logic [4:0] p4_oe_i,
  input wire logic [4:0] p4_ext_i,
  output logic [4:0] p4_pin_o
);
  // A pin the port does not drive takes the level of the outside party.
  assign p2_pin_o = (p2_oe_i & p2_out_i) | (~p2_oe_i & p2_ext_i);
  assign p3_pin_o = (p3_oe_i & p3_out_i) | (~p3_oe_i & p3_ext_i);
  assign p4_pin_o = (p4_oe_i & p4_out_i) | (~p4_oe_i & p4_ext_i);
endmodule : pfm_ext_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench of the port 2/3/4 pin function multiplexer.
// Assumes a classic Wishbone slave that acks one cycle after a request.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, e;
  logic [7:0] p2_out, p2_oe, p2_pin, p2_ext = 8'h00, r;
  logic [3:0] p3_out, p3_oe, p3_pin, p3_ext = 4'h0, cs = 4'h0;
  logic [4:0] p4_out, p4_oe, p4_pin, p4_pu, p4_ext = 5'h00;
  logic [23:0] addr = 24'h0;
  logic t0 = 0, t1 = 0, scl_d = 0, sda_d = 0, ale = 0, txd = 0, sck = 0, sysck = 0;
  logic bwait, external_interrupt_three, external_interrupt_four, cap0, cap1, scl, sda, rxd, sclkc;
  logic [31:0] expq[$];
  int error_cnt = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  pfm_port_mux u_pfm_port_mux (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port2_in_i(p2_pin), .port2_out_o(p2_out), .port2_oe_o(p2_oe),
    .port3_in_i(p3_pin), .port3_out_o(p3_out), .port3_oe_o(p3_oe), .port4_in_i(p4_pin),
    .port4_out_o(p4_out), .port4_oe_o(p4_oe), .port4_pullup_o(p4_pu), .address_i(addr),
    .timer_output_zero_i(t0), .timer_output_one_i(t1), .serial_bus_clock_drive_i(scl_d),
    .serial_bus_data_drive_i(sda_d), .chip_select_i(cs), .address_latch_enable_i(ale),
    .serial_channel_transmit_i(txd), .serial_channel_clock_drive_i(sck),
    .system_clock_output_i(sysck), .bus_wait_o(bwait), .external_interrupt_three_o(external_interrupt_three),
    .external_interrupt_four_o(external_interrupt_four), .timer_capture_input_zero_o(cap0),
    .timer_capture_input_one_o(cap1), .serial_bus_clock_line_o(scl),
    .serial_bus_data_line_o(sda), .serial_channel_receive_o(rxd),
    .serial_channel_clock_or_cts_o(sclkc));
  pfm_ext_model u_pfm_ext_model (.p2_out_i(p2_out), .p2_oe_i(p2_oe), .p2_ext_i(p2_ext),
    .p2_pin_o(p2_pin), .p3_out_i(p3_out), .p3_oe_i(p3_oe), .p3_ext_i(p3_ext),
    .p3_pin_o(p3_pin), .p4_out_i(p4_out), .p4_oe_i(p4_oe), .p4_ext_i(p4_ext),
    .p4_pin_o(p4_pin));
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, d};
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      error_cnt++;
      $display("Error ack expected 1 seen %b", ack);
      print_verdict();
    end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    sel <= 4'h0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    wb(a, 1'b0, 8'h00);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle
  // Read data is judged in the ack cycle against the oldest expectation.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        error_cnt++;
        $display("Error read note expected 1 seen 0");
      end else begin
        e = expq.pop_front();
        `CHK("read data", e, rdat)
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("Error run end expected before limit seen limit");
    print_verdict();
  end
  initial begin
    void'($urandom(14093));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("p2 oe", 8'h00, p2_oe)
    `CHK("p3 oe", 4'h0, p3_oe)
    `CHK("p4 oe", 5'h00, p4_oe)
    `CHK("p4 pullup", 5'h1F, p4_pu)
    r = 8'($urandom);
    p2_ext <= r; p3_ext <= 4'hA; p4_ext <= 5'h15; addr <= 24'($urandom);
    settle;
    rd(8'h18, {24'h0, r});
    rd(8'h20, 32'h0);
    rd(8'hFC, 32'h0);
    rd(8'h30, 32'h0000000A);
    `CHK("rxd", p4_ext[2], rxd)
    `CHK("sclk cts", p4_ext[3], sclkc)
    wb(8'h20, 1'b1, 8'hFF);
    settle;
    `CHK("p2 out", 8'hFF, p2_out)
    `CHK("p2 oe", 8'hFF, p2_oe)
    r = 8'($urandom);
    wb(8'h18, 1'b1, r);
    settle;
    `CHK("p2 out", r, p2_out)
    rd(8'h18, {24'h0, r});
    wb(8'h24, 1'b1, 8'hFF);
    settle;
    `CHK("p2 high address", addr[23:16], p2_out)
    wb(8'h20, 1'b1, 8'h00);
    settle;
    `CHK("p2 low address", addr[7:0], p2_out)
    wb(8'h38, 1'b1, 8'h00);
    wb(8'h3C, 1'b1, 8'hF7);
    for (int i = 0; i < 2; i++) begin
      p3_ext <= i ? 4'h5 : 4'hA;
      settle;
      `CHK("wait", p3_ext[2], bwait)
      `CHK("external_interrupt_three", p3_ext[0], external_interrupt_three)
      `CHK("cap0", p3_ext[0], cap0)
      `CHK("external_interrupt_four", p3_ext[1], external_interrupt_four)
      `CHK("cap1", p3_ext[1], cap1)
      `CHK("p3 oe", 4'h0, p3_oe)
    end
    wb(8'h3C, 1'b1, 8'h00);
    wb(8'h38, 1'b1, 8'h0F);
    settle;
    `CHK("wait idle", 1'b1, bwait)
    `CHK("external_interrupt_three idle", 1'b0, external_interrupt_three)
    `CHK("p3 out", 4'hF, p3_out)
    {t1, t0} <= 2'($urandom);
    wb(8'h3C, 1'b1, 8'h0F);
    settle;
    `CHK("p3 timers", {t1, t0}, p3_out[3:2])
    `CHK("p3 oe", 4'hC, p3_oe)
    wb(8'h3C, 1'b1, 8'h00);
    wb(8'h34, 1'b1, 8'h03);
    wb(8'h80, 1'b1, 8'h01);
    sda_d <= 1'b1; scl_d <= 1'b0;
    settle;
    `CHK("p3 oe serial", 2'b10, p3_oe[1:0])
    `CHK("scl pin", 1'b0, p3_out[1])
    `CHK("sda line", p3_ext[0], sda)
    `CHK("scl line", 1'b0, scl)
    wb(8'h80, 1'b1, 8'h00);
    settle;
    `CHK("p3 oe push", 2'b11, p3_oe[1:0])
    wb(8'h40, 1'b1, 8'h0A);
    settle;
    `CHK("p4 pullup", 5'h0A, p4_pu)
    `CHK("p4 oe", 5'h00, p4_oe)
    cs <= 4'($urandom); ale <= 1'b1;
    wb(8'h4C, 1'b1, 8'h1F);
    wb(8'h48, 1'b1, 8'h1F);
    settle;
    `CHK("p4 selects", {ale, cs}, p4_out)
    `CHK("p4 oe", 5'h1F, p4_oe)
    wb(8'h80, 1'b1, 8'h04);
    cs[1] <= 1'b1;
    settle;
    `CHK("p4 pin1 oe", 1'b0, p4_oe[1])
    {sck, txd, sysck} <= 3'($urandom);
    wb(8'h4C, 1'b1, 8'h00);
    wb(8'h44, 1'b1, 8'h0B);
    settle;
    `CHK("p4 second", {1'b0, sck, 1'b0, txd, sysck}, p4_out)
    `CHK("p4 second oe", {3'b111, ~txd, 1'b1}, p4_oe)
    `CHK("sclk cts idle", 1'b1, sclkc)
    `CHK("rxd driven", 1'b0, rxd)
    repeat (5) @(posedge clk_i);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
